// ### src/differential_trip_decision.sv
`timescale 1ns/1ps
`include "diff_trip_defines.svh"

// What this block does
// - disable input suppresses all starts only
// - per-phase restrained start above characteristic
// - restrained general start ORs three phases
// - per-phase unrestrained start above high threshold
// - unrestrained general start on any phase
// - summary second harmonic restraint output
// - summary fifth harmonic restraint output
// - adaptive entry: bias high 3 ms, diff low
// - adaptive exit when bias below 0.8 In
// - adaptive uses slopes 50 and 200 percent
// - second harmonic only at 75 degrees or more apart
// - general starts go to fast trip path
// - separate fifth harmonic input per phase
module differential_trip_decision #(
    parameter int W = 16,
    parameter int MS_TICK = `MS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic protection_disable_in,
    input wire logic [3*W-1:0] idiff,
    input wire logic [3*W-1:0] ibias,
    input wire logic [8:0] angle_diff_deg,
    input wire logic [2:0] second_harmonic_high,
    input wire logic [2:0] fifth_harmonic_restraint_in,
    output logic restrained_start_ph1,
    output logic restrained_start_ph2,
    output logic restrained_start_ph3,
    output logic restrained_general_start,
    output logic unrestrained_start_ph1,
    output logic unrestrained_start_ph2,
    output logic unrestrained_start_ph3,
    output logic unrestrained_general_start,
    output logic second_harmonic_restraint_out,
    output logic fifth_harmonic_restraint_out,
    output logic fast_trip_restrained,
    output logic fast_trip_unrestrained,
    output logic adaptive_active
);
    // ==========================================================
    // register file
    logic enable;
    diff_trip_pkg::pct_t base_sens;
    diff_trip_pkg::pct_t slope1;
    diff_trip_pkg::pct_t slope2;
    diff_trip_pkg::pct_t bias_limit;
    diff_trip_pkg::pct_t unrestr;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic block_all;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS)
        || (paddr == `REG_BASE_SENS) || (paddr == `REG_SLOPE1)
        || (paddr == `REG_SLOPE2) || (paddr == `REG_BIAS_LIMIT)
        || (paddr == `REG_UNRESTR);
    assign pslverr = psel && penable && !addr_ok;

    // config writes land at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'(`CTRL_RESET_VAL);
            base_sens <= `BASE_SENS_RESET;
            slope1 <= `SLOPE1_RESET;
            slope2 <= `SLOPE2_RESET;
            bias_limit <= `BIAS_LIMIT_RESET;
            unrestr <= `UNRESTR_RESET;
        end else if (wr_en) begin
            case (paddr)
                `REG_CTRL: enable <= pwdata[`CTRL_ENABLE_BIT];
                `REG_BASE_SENS: base_sens <= pwdata[15:0];
                `REG_SLOPE1: slope1 <= pwdata[15:0];
                `REG_SLOPE2: slope2 <= pwdata[15:0];
                `REG_BIAS_LIMIT: bias_limit <= pwdata[15:0];
                `REG_UNRESTR: unrestr <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    assign status_word = {20'h0, adaptive_active,
        fifth_harmonic_restraint_out, second_harmonic_restraint_out,
        unrestrained_general_start, restrained_general_start,
        unrestrained_start_ph3, unrestrained_start_ph2,
        unrestrained_start_ph1, restrained_start_ph3,
        restrained_start_ph2, restrained_start_ph1, block_all};

    always_comb begin
        case (paddr)
            `REG_CTRL: rd_mux = {31'h0, enable};
            `REG_STATUS: rd_mux = status_word;
            `REG_BASE_SENS: rd_mux = {16'h0, base_sens};
            `REG_SLOPE1: rd_mux = {16'h0, slope1};
            `REG_SLOPE2: rd_mux = {16'h0, slope2};
            `REG_BIAS_LIMIT: rd_mux = {16'h0, bias_limit};
            `REG_UNRESTR: rd_mux = {16'h0, unrestr};
            default: rd_mux = 32'h0;
        endcase
    end

    // read data captured in setup so it is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end

    // ==========================================================
    // pin synchroniser for the external disable input only
    logic ctl_meta;
    logic ctl_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_meta <= 1'b0;
            ctl_sync <= 1'b0;
        end else begin
            ctl_meta <= protection_disable_in;
            ctl_sync <= ctl_meta;
        end
    end

    // operation off acts like the external disable
    assign block_all = ctl_sync || !enable;

    // ==========================================================
    // millisecond time base
    logic [$clog2(MS_TICK+1)-1:0] tick_cnt;
    logic ms_tick;

    assign ms_tick = (tick_cnt == ($bits(tick_cnt))'(MS_TICK - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // ==========================================================
    // adaptive characteristic detection
    diff_trip_pkg::adapt_state_e state;
    diff_trip_pkg::adapt_state_e next_state;
    logic [2:0] ms_cnt;
    logic [2:0] bias_high;
    logic [2:0] diff_low;
    logic [2:0] bias_low;
    logic entry_cond;
    logic all_low;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cmp
            assign bias_high[g] = ibias[g*W +: W] > W'(`ADAPT_ENTRY_BIAS_PCT);
            assign bias_low[g] = ibias[g*W +: W] < W'(`ADAPT_EXIT_BIAS_PCT);
            assign diff_low[g] = idiff[g*W +: W] < base_sens;
        end
    endgenerate

    assign entry_cond = |(bias_high & diff_low);
    assign all_low = &bias_low;
    assign adaptive_active = (state == diff_trip_pkg::ADAPTIVE);

    always_comb begin
        next_state = state;
        case (state)
            diff_trip_pkg::NORMAL:
                if (entry_cond) next_state = diff_trip_pkg::ARMING;
            diff_trip_pkg::ARMING:
                if (!entry_cond) begin
                    next_state = diff_trip_pkg::NORMAL;
                end else if (ms_tick &&
                        ms_cnt == 3'(`ADAPT_ENTRY_MS)) begin
                    next_state = diff_trip_pkg::ADAPTIVE;
                end
            diff_trip_pkg::ADAPTIVE:
                if (all_low) next_state = diff_trip_pkg::NORMAL;
            default: next_state = diff_trip_pkg::NORMAL;
        endcase
    end

    // ms_cnt counts whole ticks, so entry takes 3 to 4 ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= diff_trip_pkg::NORMAL;
            ms_cnt <= 3'h0;
        end else begin
            state <= next_state;
            if (next_state != diff_trip_pkg::ARMING) begin
                ms_cnt <= 3'h0;
            end else if (ms_tick) begin
                ms_cnt <= ms_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // characteristic evaluation per phase
    diff_trip_pkg::pct_t use_slope1;
    diff_trip_pkg::pct_t use_slope2;
    logic [2:0] above_r;
    logic [2:0] above_u;
    logic [2:0] harm_block;
    logic [2:0] second_gated;
    logic angle_ok;

    // adaptive mode swaps in the desensitised slopes
    assign use_slope1 = adaptive_active ?
        16'(`ADAPT_SLOPE1_PCT) : slope1;
    assign use_slope2 = adaptive_active ?
        16'(`ADAPT_SLOPE2_PCT) : slope2;

    generate
        for (g = 0; g < 3; g++) begin : g_phase
            phase_characteristic #(.W(W)) u_char (
                .idiff(idiff[g*W +: W]),
                .ibias(ibias[g*W +: W]),
                .base_sens(base_sens),
                .slope1(use_slope1),
                .slope2(use_slope2),
                .bias_limit(bias_limit),
                .unrestr(unrestr),
                .above_restrained(above_r[g]),
                .above_unrestrained(above_u[g])
            );
        end
    endgenerate

    assign angle_ok = angle_diff_deg >= 9'(`ANGLE_MIN_DEG);
    assign second_gated = second_harmonic_high & {3{angle_ok}};
    assign harm_block = second_gated
        | fifth_harmonic_restraint_in;

    // ==========================================================
    // registered decision outputs
    logic [2:0] next_rs;
    logic [2:0] next_us;

    assign next_rs = above_r & ~harm_block & {3{!block_all}};
    assign next_us = above_u & {3{!block_all}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {restrained_start_ph3, restrained_start_ph2,
                restrained_start_ph1} <= 3'h0;
            {unrestrained_start_ph3, unrestrained_start_ph2,
                unrestrained_start_ph1} <= 3'h0;
            restrained_general_start <= 1'b0;
            unrestrained_general_start <= 1'b0;
            second_harmonic_restraint_out <= 1'b0;
            fifth_harmonic_restraint_out <= 1'b0;
        end else begin
            {restrained_start_ph3, restrained_start_ph2,
                restrained_start_ph1} <= next_rs;
            {unrestrained_start_ph3, unrestrained_start_ph2,
                unrestrained_start_ph1} <= next_us;
            restrained_general_start <= |next_rs;
            unrestrained_general_start <= |next_us;
            second_harmonic_restraint_out <= |second_gated;
            fifth_harmonic_restraint_out <=
                |fifth_harmonic_restraint_in;
        end
    end

    // fast trip path takes the general starts directly
    assign fast_trip_restrained = restrained_general_start;
    assign fast_trip_unrestrained = unrestrained_general_start;

    // ==========================================================
    // checks
    property p_disable;
        @(posedge pclk) disable iff (!presetn)
        block_all |=> !restrained_general_start
            && !unrestrained_general_start;
    endproperty
    a_disable: assert property (p_disable)
        else $error("start while disabled");

    property p_gen_r;
        @(posedge pclk) disable iff (!presetn)
        restrained_general_start == (restrained_start_ph1
            || restrained_start_ph2 || restrained_start_ph3);
    endproperty
    a_gen_r: assert property (p_gen_r)
        else $error("general mismatch");

    property p_unr;
        @(posedge pclk) disable iff (!presetn)
        (above_u[0] && !block_all) |=> unrestrained_start_ph1;
    endproperty
    a_unr: assert property (p_unr)
        else $error("unrestrained missed");

    property p_gen_u;
        @(posedge pclk) disable iff (!presetn)
        (|above_u && !block_all) |=> unrestrained_general_start;
    endproperty
    a_gen_u: assert property (p_gen_u)
        else $error("unr general missed");

    property p_restr;
        @(posedge pclk) disable iff (!presetn)
        (harm_block[0] || block_all) |=> !restrained_start_ph1;
    endproperty
    a_restr: assert property (p_restr)
        else $error("restrained not held");

    property p_fifth;
        @(posedge pclk) disable iff (!presetn)
        $rose(fifth_harmonic_restraint_in[1]) |=>
            fifth_harmonic_restraint_out;
    endproperty
    a_fifth: assert property (p_fifth)
        else $error("fifth missed");

    property p_angle;
        @(posedge pclk) disable iff (!presetn)
        !angle_ok |=> !second_harmonic_restraint_out;
    endproperty
    a_angle: assert property (p_angle)
        else $error("second without angle");

    property p_exit;
        @(posedge pclk) disable iff (!presetn)
        (adaptive_active && all_low) |=> !adaptive_active;
    endproperty
    a_exit: assert property (p_exit)
        else $error("adaptive stuck");

    property p_entry;
        @(posedge pclk) disable iff (!presetn)
        $rose(adaptive_active) |-> $past(entry_cond) && ms_cnt == 3'h0;
    endproperty
    a_entry: assert property (p_entry)
        else $error("bad entry");

    property p_slope;
        @(posedge pclk) disable iff (!presetn)
        adaptive_active |-> use_slope1 == 16'h0032 && use_slope2 == 16'h00c8;
    endproperty
    a_slope: assert property (p_slope)
        else $error("slopes wrong");
endmodule

// ### src/diff_trip_defines.svh
`ifndef DIFF_TRIP_DEFINES_SVH
`define DIFF_TRIP_DEFINES_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS 10
`define MS_IN_NS 1000000
`define MS_TICK_CYCLES (`MS_IN_NS / `CLK_PERIOD_NS)
`define ADAPT_ENTRY_MS 3

// ==========================================================
// current thresholds and slopes in percent of nominal, angle in degrees
`define ADAPT_ENTRY_BIAS_PCT 125
`define ADAPT_EXIT_BIAS_PCT 80
`define ADAPT_SLOPE1_PCT 50
`define ADAPT_SLOPE2_PCT 200
`define ANGLE_MIN_DEG 75

// ==========================================================
// register map
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_BASE_SENS 12'h008
`define REG_SLOPE1 12'h00c
`define REG_SLOPE2 12'h010
`define REG_BIAS_LIMIT 12'h014
`define REG_UNRESTR 12'h018
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VAL 32'h00000001
`define BASE_SENS_RESET 16'h0014
`define SLOPE1_RESET 16'h0014
`define SLOPE2_RESET 16'h00c8
`define BIAS_LIMIT_RESET 16'h00c8
`define UNRESTR_RESET 16'h0320

`endif

// ### src/diff_trip_pkg.sv
package diff_trip_pkg;
    typedef enum logic [1:0] {
        NORMAL,
        ARMING,
        ADAPTIVE
    } adapt_state_e;
    typedef logic [15:0] pct_t;
endpackage

// ### src/phase_characteristic.sv
`timescale 1ns/1ps
`include "diff_trip_defines.svh"

// per-phase comparison of differential current against the
// restrained characteristic and the unrestrained threshold;
// currents are in percent of nominal
module phase_characteristic #(
    parameter int W = 16
) (
    input wire logic [W-1:0] idiff,
    input wire logic [W-1:0] ibias,
    input wire logic [W-1:0] base_sens,
    input wire logic [W-1:0] slope1,
    input wire logic [W-1:0] slope2,
    input wire logic [W-1:0] bias_limit,
    input wire logic [W-1:0] unrestr,
    output logic above_restrained,
    output logic above_unrestrained
);
    // ==========================================================
    // characteristic line, scaled by 100 to avoid division
    logic [2*W+7:0] lim1;
    logic [2*W+7:0] lim2;
    logic [2*W+7:0] diff100;
    logic [2*W+7:0] base100;
    logic [2*W+7:0] sect2;
    logic [2*W+7:0] sect3;
    logic [2*W+7:0] thresh;

    assign diff100 = (2*W+8)'(idiff) * (2*W+8)'(100);
    assign base100 = (2*W+8)'(base_sens) * (2*W+8)'(100);
    assign lim1 = (2*W+8)'(ibias) * (2*W+8)'(slope1);
    // second slope continues from the end of the first section
    assign lim2 = (2*W+8)'(bias_limit) * (2*W+8)'(slope1)
        + (2*W+8)'(ibias - bias_limit) * (2*W+8)'(slope2);
    assign sect2 = (lim1 > base100) ? lim1 : base100;
    assign sect3 = (lim2 > base100) ? lim2 : base100;
    assign thresh = (ibias > bias_limit) ? sect3 : sect2;
    assign above_restrained = diff100 > thresh;
    assign above_unrestrained = idiff > unrestr;
endmodule

// ### testbench/trip_partner.sv
`timescale 1ns/1ps

// ==========================================================
// user blocking equation and fast trip logic on the far side
module trip_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic block_req,
    input wire logic fast_trip_restrained,
    input wire logic fast_trip_unrestrained,
    output logic protection_disable_in,
    output logic trip_seen
);
    // equation output is registered, so it only moves after an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_disable_in <= 1'b0;
            trip_seen <= 1'b0;
        end else begin
            protection_disable_in <= block_req;
            trip_seen <= fast_trip_restrained
                | fast_trip_unrestrained;
        end
    end
endmodule

// ### testbench/tb_differential_trip_decision.sv
`timescale 1ns/1ps

// ==========================================================
// bench for the decision logic
module tb_differential_trip_decision;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic block_req, disable_pin, err, blk, m_adapt, m_en;
    logic [47:0] idiff, ibias;
    logic [8:0] angle_diff_deg;
    logic [2:0] second_harmonic_high, fifth_harmonic_restraint_in;
    logic [2:0] rs, us, sh, fh;
    logic rgen, ugen, h2o, h5o, ftr, ftu, adapt, trip;
    int miscompares = 0;
    int samples_checked = 0;
    int d[3], b[3], ang, base = 20, unr = 800;
    int angs[4] = '{0, 74, 75, 180};
    int regs[7] = '{1, 0, 20, 20, 200, 200, 800};

    differential_trip_decision #(
        .MS_TICK(10)
    ) differential_trip_decision_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .protection_disable_in(disable_pin), .idiff(idiff), .ibias(ibias),
        .angle_diff_deg(angle_diff_deg),
        .second_harmonic_high(second_harmonic_high),
        .fifth_harmonic_restraint_in(fifth_harmonic_restraint_in),
        .restrained_start_ph1(rs[0]), .restrained_start_ph2(rs[1]),
        .restrained_start_ph3(rs[2]), .restrained_general_start(rgen),
        .unrestrained_start_ph1(us[0]), .unrestrained_start_ph2(us[1]),
        .unrestrained_start_ph3(us[2]), .unrestrained_general_start(ugen),
        .second_harmonic_restraint_out(h2o),
        .fifth_harmonic_restraint_out(h5o),
        .fast_trip_restrained(ftr), .fast_trip_unrestrained(ftu),
        .adaptive_active(adapt)
    );

    trip_partner trip_partner_inst (
        .pclk(pclk), .presetn(presetn), .block_req(block_req),
        .fast_trip_restrained(ftr), .fast_trip_unrestrained(ftu),
        .protection_disable_in(disable_pin), .trip_seen(trip)
    );

    // ==========================================================
    // clock, 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // reference model: characteristic guessed only at clear margins
    function automatic logic [13:0] model();
        logic [2:0] r, u, h;
        int thr;
        logic blocked;
        blocked = blk | !m_en;
        for (int p = 0; p < 3; p++) begin
            h[p] = sh[p] && ang >= 75;
            thr = base + (m_adapt ? 50 : 20) * b[p] / 100;
            r[p] = d[p] > thr && !h[p] && !fh[p] && !blocked;
            u[p] = d[p] > unr && !blocked;
        end
        // last bit: far side sees a fast trip once inputs have settled
        return {r, |r, u, |u, |h, |fh, |r, |u, m_adapt, (|r) | (|u)};
    endfunction

    task automatic report(input logic [32:0] exp, input logic [32:0] act);
        samples_checked++;
        if (act !== exp) begin
            miscompares++;
            $display("MISMATCH %0t exp %h got %h", $time, exp, act);
        end
    endtask

    task automatic chk_out(input logic [13:0] exp);
        report({19'h0, exp},
            {19'h0, rs, rgen, us, ugen, h2o, h5o, ftr, ftu, adapt, trip});
    endtask

    task automatic chk_reg(input logic [32:0] exp);
        report(exp, {err, rd});
    endtask

    // inputs move just after an edge; outputs are read mid-cycle
    task automatic drive(input int n);
        @(posedge pclk);
        idiff <= {d[2][15:0], d[1][15:0], d[0][15:0]};
        ibias <= {b[2][15:0], b[1][15:0], b[0][15:0]};
        angle_diff_deg <= 9'(ang);
        second_harmonic_high <= sh;
        fifth_harmonic_restraint_in <= fh;
        block_req <= blk;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        chk_out(model());
    endtask

    // one apb transfer; only the watchdog ends a stuck wait
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hb1dd7fe8));
        presetn = 1'b0;
        {psel, penable, pwrite, block_req, blk, m_adapt} = 6'h00;
        m_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        {idiff, ibias} = 96'h0;
        angle_diff_deg = 9'h000;
        {sh, fh, second_harmonic_high, fifth_harmonic_restraint_in} = 12'h000;
        d = '{0, 0, 0};
        b = '{0, 0, 0};
        ang = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk_reg({1'b0, 32'(regs[i])});
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk_reg({1'b1, 32'h0});
        // mixed vectors with boundary thresholds and angles
        for (int k = 0; k < 40; k++) begin
            for (int p = 0; p < 3; p++) begin
                case ($urandom % 4)
                    0: d[p] = $urandom % 11;
                    1: d[p] = 150 + $urandom % 500;
                    2: d[p] = 801 + $urandom % 500;
                    default: d[p] = 800;
                endcase
                b[p] = $urandom % 101;
            end
            sh = 3'($urandom);
            fh = 3'($urandom);
            ang = angs[$urandom % 4];
            blk = ($urandom % 4) == 0;
            drive(5);
            // the same call also
        end
        // software disable blocks starts, status still readable
        {sh, fh, blk} = 7'h00;
        d = '{900, 900, 900};
        b = '{0, 0, 0};
        apb(1'b1, 12'h000, 32'h00000000);
        m_en = 1'b0;
        drive(5);
        apb(1'b0, 12'h004, 32'h00000000);
        chk_reg({1'b0, 32'h00000001});
        apb(1'b1, 12'h000, 32'h00000001);
        m_en = 1'b1;
        // raised unrestrained threshold, strictly above
        apb(1'b1, 12'h018, 32'h00000384);
        unr = 900;
        d = '{850, 901, 900};
        drive(5);
        apb(1'b1, 12'h018, 32'h00000320);
        unr = 800;
        // adaptive entry, desensitised slope, hysteresis and exit
        d = '{0, 0, 0};
        b = '{0, 200, 0};
        drive(5);
        drive(20);
        m_adapt = 1'b1;
        drive(30);
        d = '{0, 80, 0};
        drive(5);
        b = '{0, 100, 0};
        drive(5);
        b = '{0, 79, 0};
        m_adapt = 1'b0;
        drive(5);
        // high bias with differential above base never arms
        d = '{0, 30, 0};
        b = '{0, 200, 0};
        drive(60);
        finish_test();
    end
endmodule
